// *** verilog/sensor_bus_defs.svh ***
// Purpose: Constants of the single-wire sensor bus master.
// Assumes: Times are in microseconds unless named otherwise.
// Notes:   Cycle counts are derived inside the modules.
`ifndef SENSOR_BUS_DEFS_SVH
`define SENSOR_BUS_DEFS_SVH

// Clock rate in MHz, which is also cycles per microsecond.
`define CLK_MHZ       250
`define US_PER_MS     1000

// Line timing in microseconds.
`define RST_LOW_US    480
`define RST_REC_US    480
`define PRES_SAMP_US  70
`define SLOT_US       70
`define SLOT_MIN_US   60
`define REC_US        2
`define REC_MIN_US    1
`define W0_LOW_US     65
`define W0_MIN_US     60
`define W1_LOW_US     6
`define W1_MAX_US     15
`define RD_LOW_US     2
`define RD_SAMP_US    12

// Strong pullup hold in milliseconds.
`define SPU_MIN_MS    16'h000A
`define SPU_MS_RST    16'h02EE

// Register byte offsets.
`define A_CTRL        12'h000
`define A_STATUS      12'h004
`define A_SPU_MS      12'h008
`define A_CRC         12'h00C

// Control fields and operation codes.
`define CTRL_SPU_BIT  3
`define OPC_RESET     3'h1
`define OPC_WRBYTE    3'h2
`define OPC_RDBYTE    3'h3
`define OPC_RDBIT     3'h4
`define OPC_WRBIT     3'h5

// Status fields.
`define ST_REFUSED    5

// Write-scratchpad guard: command byte and its legal byte positions.
`define CMD_WRITE_SP  8'h4E
`define WSP_POS_SKIP  4'h1
`define WSP_POS_MATCH 4'h9

`endif

// *** verilog/sensor_bus_pkg.sv ***
// Purpose: Types shared by the sensor bus master modules.
// Assumes: Nothing beyond the defs header.
// Notes:   State enums carry no codes.
package sensor_bus_pkg;
  typedef enum logic [1:0] {SLOT_RST, SLOT_WR, SLOT_RD, SLOT_SPU} slot_op_e;
  typedef enum logic [1:0] {ENG_IDLE, ENG_LOW, ENG_REL} eng_state_e;
  typedef enum logic [1:0] {CTL_IDLE, CTL_ISSUE, CTL_WAIT} ctl_state_e;
endpackage

// *** verilog/sensor_slot_if.sv ***
// Purpose: Slot request and answer path between controller and engine.
// Assumes: One clock, driven from the controller's domain.
// Notes:   start is a one-cycle pulse taken only while the engine idles.
`timescale 1ns/10ps
interface sensor_slot_if;
  import sensor_bus_pkg::*;
  logic        start;
  slot_op_e    op;
  logic        wbit;
  logic [15:0] spu_ms;
  logic        done;
  logic        rbit;
  logic        presence;
  logic        dq_oe;
  logic        spu_oe;
  modport ctrl (output start, op, wbit, spu_ms,
                input  done, rbit, presence, dq_oe, spu_oe);
  modport eng  (input  start, op, wbit, spu_ms,
                output done, rbit, presence, dq_oe, spu_oe);
endinterface

// *** verilog/crc8_acc.sv ***
// Purpose: Serial check-byte accumulator, least significant bit first.
// Assumes: en pulses once per received bit.
// Notes:   Over data plus check byte a good frame leaves zero.
`timescale 1ns/10ps
module crc8_acc (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bit stream.
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic       din,
  output logic [7:0]      crc
);
  logic [7:0] crc_r;
  logic [7:0] crc_nxt;
  logic       fb;

  // Shift in one bit of x^8+x^5+x^4+1, reflected form.
  always_comb begin
    fb      = crc_r[0] ^ din;
    crc_nxt = crc_r;
    if (clr) begin
      crc_nxt = 8'h00;
    end else if (en) begin
      crc_nxt = {1'b0, crc_r[7:1]} ^ (fb ? 8'h8C : 8'h00);
    end
  end

  // Register stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_r <= 8'h00;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crc = crc_r;
endmodule

// *** verilog/slot_engine.sv ***
// Purpose: Times reset, write, read and strong-pullup slots on the line.
// Assumes: dq_i is the raw open-drain line level.
// Notes:   All times are counted from the slot's own start.
`timescale 1ns/10ps
`include "sensor_bus_defs.svh"
module slot_engine
  import sensor_bus_pkg::*;
#(
  parameter int unsigned CYC_US      = `CLK_MHZ,
  parameter int unsigned RST_LOW_CYC = `RST_LOW_US * CYC_US,
  parameter int unsigned RST_REC_CYC = `RST_REC_US * CYC_US,
  parameter int unsigned PRES_CYC    = `PRES_SAMP_US * CYC_US,
  parameter int unsigned SLOT_CYC    = `SLOT_US * CYC_US,
  parameter int unsigned W0_LOW_CYC  = `W0_LOW_US * CYC_US,
  parameter int unsigned MS_CYC      = `US_PER_MS * CYC_US
)(
  // Clock and reset.
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Line sense.
  input  wire logic  dq_i,
  // Slot port.
  sensor_slot_if.eng s
);
  localparam int unsigned END_CYC = SLOT_CYC + `REC_US * CYC_US;
  localparam int SLOT_MIN_C = (`SLOT_MIN_US + `REC_MIN_US) * CYC_US;
  localparam int W0_MIN_C   = `W0_MIN_US * CYC_US;
  localparam int W1_MAX_C   = `W1_MAX_US * CYC_US;
  localparam int SPU_MIN_C  = `SPU_MIN_MS * MS_CYC;

  eng_state_e  st_r, st_nxt;
  slot_op_e    op_r, op_nxt;
  logic        bit_r, bit_nxt, dq_oe_r, dq_oe_nxt, spu_oe_r, spu_oe_nxt;
  logic        done_r, done_nxt, rbit_r, rbit_nxt, pres_r, pres_nxt;
  logic        dq_s1_r, dq_s2_r;
  logic [19:0] cnt_r, cnt_nxt, low_len, samp_at, end_at;
  logic [15:0] ms_r, ms_nxt;
  logic [19:0] low_run_r, slot_run_r;
  logic [31:0] spu_run_r;

  // Slot shape per operation.
  always_comb begin
    low_len = 20'(`RD_LOW_US * CYC_US);
    samp_at = 20'(`RD_SAMP_US * CYC_US);
    end_at  = 20'(END_CYC);
    unique case (op_r)
      SLOT_RST: begin
        low_len = 20'(RST_LOW_CYC);
        samp_at = 20'(RST_LOW_CYC + PRES_CYC);
        end_at  = 20'(RST_LOW_CYC + RST_REC_CYC);
      end
      SLOT_WR: begin
        low_len = bit_r ? 20'(`W1_LOW_US * CYC_US) : 20'(W0_LOW_CYC);
        samp_at = 20'(END_CYC);
      end
      SLOT_RD: begin
      end
      SLOT_SPU: begin
      end
    endcase
  end

  // Slot sequencer.
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    bit_nxt = bit_r;
    cnt_nxt = cnt_r;
    ms_nxt = ms_r;
    dq_oe_nxt = dq_oe_r;
    spu_oe_nxt = spu_oe_r;
    done_nxt = 1'b0;
    rbit_nxt = rbit_r;
    pres_nxt = pres_r;
    unique case (st_r)
      ENG_IDLE: begin
        if (s.start) begin
          op_nxt  = s.op;
          bit_nxt = s.wbit;
          cnt_nxt = 20'h00000;
          if (s.op == SLOT_SPU) begin
            spu_oe_nxt = 1'b1;
            ms_nxt = (s.spu_ms < `SPU_MIN_MS) ? `SPU_MIN_MS : s.spu_ms;
            st_nxt = ENG_REL;
          end else begin
            dq_oe_nxt = 1'b1;
            st_nxt = ENG_LOW;
          end
        end
      end
      ENG_LOW: begin
        cnt_nxt = cnt_r + 20'h00001;
        if (cnt_r == low_len - 20'h00001) begin
          dq_oe_nxt = 1'b0;
          st_nxt = ENG_REL;
        end
      end
      ENG_REL: begin
        cnt_nxt = cnt_r + 20'h00001;
        if (op_r == SLOT_SPU) begin
          if (cnt_r == 20'(MS_CYC - 1)) begin
            cnt_nxt = 20'h00000;
            ms_nxt = ms_r - 16'h0001;
            if (ms_r == 16'h0001) begin
              spu_oe_nxt = 1'b0;
              done_nxt = 1'b1;
              st_nxt = ENG_IDLE;
            end
          end
        end else begin
          if (cnt_r == samp_at) begin
            if (op_r == SLOT_RST) begin
              pres_nxt = !dq_s2_r;
            end else begin
              rbit_nxt = dq_s2_r;
            end
          end
          if (cnt_r == end_at - 20'h00001) begin
            done_nxt = 1'b1;
            st_nxt = ENG_IDLE;
          end
        end
      end
    endcase
  end

  // Registers, line synchroniser and assertion helpers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ENG_IDLE;
      op_r <= SLOT_RST;
      bit_r <= 1'b0;
      cnt_r <= 20'h00000;
      ms_r <= 16'h0000;
      dq_oe_r <= 1'b0;
      spu_oe_r <= 1'b0;
      done_r <= 1'b0;
      rbit_r <= 1'b0;
      pres_r <= 1'b0;
      dq_s1_r <= 1'b1;
      dq_s2_r <= 1'b1;
      low_run_r <= 20'h00000;
      slot_run_r <= 20'h00000;
      spu_run_r <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      bit_r <= bit_nxt;
      cnt_r <= cnt_nxt;
      ms_r <= ms_nxt;
      dq_oe_r <= dq_oe_nxt;
      spu_oe_r <= spu_oe_nxt;
      done_r <= done_nxt;
      rbit_r <= rbit_nxt;
      pres_r <= pres_nxt;
      dq_s1_r <= dq_i;
      dq_s2_r <= dq_s1_r;
      low_run_r <= dq_oe_r ? low_run_r + 20'h00001 : 20'h00000;
      slot_run_r <= (st_r != ENG_IDLE) ? slot_run_r + 20'h00001 :
                    (s.start ? 20'h00000 : slot_run_r);
      spu_run_r <= spu_oe_r ? spu_run_r + 32'h00000001 : 32'h00000000;
    end
  end

  assign s.done = done_r;
  assign s.rbit = rbit_r;
  assign s.presence = pres_r;
  assign s.dq_oe = dq_oe_r;
  assign s.spu_oe = spu_oe_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the line timing.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rst_low;
    $fell(dq_oe_r) && op_r == SLOT_RST |-> low_run_r >= RST_LOW_CYC;
  endproperty
  a_rst_low: assert property (p_rst_low)
    else $error("Reset pulse shorter than minimum.");

  property p_w1_short;
    $fell(dq_oe_r) && op_r == SLOT_WR && bit_r |-> low_run_r <= W1_MAX_C;
  endproperty
  a_w1_short: assert property (p_w1_short)
    else $error("Write-one low phase too long.");

  property p_w0_long;
    $fell(dq_oe_r) && op_r == SLOT_WR && !bit_r |-> low_run_r >= W0_MIN_C;
  endproperty
  a_w0_long: assert property (p_w0_long)
    else $error("Write-zero low phase too short.");

  property p_slot_len;
    done_r && op_r != SLOT_SPU && op_r != SLOT_RST
      |-> slot_run_r >= SLOT_MIN_C;
  endproperty
  a_slot_len: assert property (p_slot_len)
    else $error("Slot plus recovery too short.");

  property p_quiet_spu;
    spu_oe_r |-> !dq_oe_r;
  endproperty
  a_quiet_spu: assert property (p_quiet_spu)
    else $error("Line driven during strong pullup.");

  property p_drive_cause;
    $rose(dq_oe_r) |-> $past(s.start) && $past(st_r) == ENG_IDLE;
  endproperty
  a_drive_cause: assert property (p_drive_cause)
    else $error("Line driven without a slot request.");

  property p_spu_hold;
    $fell(spu_oe_r) |-> spu_run_r >= SPU_MIN_C;
  endproperty
  a_spu_hold: assert property (p_spu_hold)
    else $error("Strong pullup released too early.");

  c_presence: cover property (done_r && op_r == SLOT_RST && pres_r);
  c_read_zero: cover property (done_r && op_r == SLOT_RD && !rbit_r);
endmodule

// *** verilog/sensor_bus_master.sv ***
// Purpose: Software-driven master for a single-wire temperature sensor.
// Assumes: APB slave, one wait state on every transfer; dq_i is the line level.
// Notes:   Line is open drain: dq_o is low, dq_oe high pulls the line.
`timescale 1ns/10ps
`include "sensor_bus_defs.svh"
// Contract
// - Strong pullup within 10 us after conversion command, held.
// - Both alarm bytes must be sent before any reset pulse.
// - A reset may end a scratchpad read at any point.
// - Strong pullup within 10 us of copy, held at least 10 ms.
// - No other line activity while strong pullup is on.
// - Master starts every signal except the presence pulse.
// - Reset pulse holds the line low at least 480 us.
// - Write slots last at least 60 us, 1 us recovery between.
// - Write one: release the line within 15 us of slot start.
// - Write zero: hold the line low the whole slot; here held low 65 us of the 70 us slot.
// - All bytes travel least significant bit first.
module sensor_bus_master
  import sensor_bus_pkg::*;
#(
  parameter int unsigned CYC_US      = `CLK_MHZ,
  parameter int unsigned RST_LOW_CYC = `RST_LOW_US * CYC_US,
  parameter int unsigned RST_REC_CYC = `RST_REC_US * CYC_US,
  parameter int unsigned PRES_CYC    = `PRES_SAMP_US * CYC_US,
  parameter int unsigned SLOT_CYC    = `SLOT_US * CYC_US,
  parameter int unsigned W0_LOW_CYC  = `W0_LOW_US * CYC_US,
  parameter int unsigned MS_CYC      = `US_PER_MS * CYC_US
)(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Sensor line and strong pullup.
  input  wire logic        dq_i,
  output logic             dq_o,
  output logic             dq_oe,
  output logic             spu_oe
);
  sensor_slot_if s ();

  ctl_state_e  st_r, st_nxt;
  slot_op_e    sop_r, sop_nxt;
  logic [2:0]  mode_r, mode_nxt, idx_r, idx_nxt, opc;
  logic [7:0]  data_r, data_nxt, rx_r, rx_nxt, crc;
  logic [15:0] spu_ms_r, spu_ms_nxt;
  logic [3:0]  pos_r, pos_nxt;
  logic [1:0]  owe_r, owe_nxt;
  logic        spu_pend_r, spu_pend_nxt, refused_r, refused_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt, rd_val;
  logic        dq_o_r;
  logic        map_ok, wr_ev, cmd_wr, op_ok, accept, crc_clr, crc_en;
  logic        byte_mode, wbyte_end;
  logic [7:0]  sent_r;

  ////////////////////////////////////////////////////////////////////////
  // Sub-blocks.

  slot_engine #(
    .CYC_US      (CYC_US),
    .RST_LOW_CYC (RST_LOW_CYC),
    .RST_REC_CYC (RST_REC_CYC),
    .PRES_CYC    (PRES_CYC),
    .SLOT_CYC    (SLOT_CYC),
    .W0_LOW_CYC  (W0_LOW_CYC),
    .MS_CYC      (MS_CYC)
  ) u_eng (
    .pclk    (pclk),
    .presetn (presetn),
    .dq_i    (dq_i),
    .s       (s)
  );

  crc8_acc u_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (crc_clr),
    .en      (crc_en),
    .din     (s.rbit),
    .crc     (crc)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register read mux and decode.

  // Read value of each register; unmapped offsets answer with an error.
  always_comb begin
    map_ok = 1'b1;
    rd_val = 32'h00000000;
    unique case (paddr)
      `A_CTRL:   rd_val = {16'h0000, data_r, 4'h0, spu_pend_r, mode_r};
      `A_STATUS: rd_val = {16'h0000, rx_r, 2'h0, refused_r, s.rbit,
                           s.spu_oe, (crc == 8'h00), s.presence,
                           (st_r != CTL_IDLE)};
      `A_SPU_MS: rd_val = {16'h0000, spu_ms_r};
      `A_CRC:    rd_val = {24'h000000, crc};
      default:   map_ok = 1'b0;
    endcase
  end

  // Command decode. A write takes effect only on the ready edge.
  always_comb begin
    wr_ev  = psel && penable && pready_r && pwrite && !pslverr_r;
    cmd_wr = wr_ev && (paddr == `A_CTRL);
    opc    = pwdata[2:0];
    op_ok  = (opc >= `OPC_RESET) && (opc <= `OPC_WRBIT);
    // Reset refused while alarm bytes owed.
    // Refused while any slot or pullup runs.
    accept = cmd_wr && op_ok && (st_r == CTL_IDLE) &&
             !(opc == `OPC_RESET && owe_r != 2'h0);
    crc_clr = (accept && opc == `OPC_RESET) ||
              (wr_ev && paddr == `A_CRC);
    byte_mode = (mode_r == `OPC_WRBYTE) || (mode_r == `OPC_RDBYTE);
    crc_en = (st_r == CTL_WAIT) && s.done && sop_r == SLOT_RD &&
             mode_r == `OPC_RDBYTE;
    wbyte_end = (st_r == CTL_WAIT) && s.done && sop_r == SLOT_WR &&
                mode_r == `OPC_WRBYTE && idx_r == 3'h7;
  end

  ////////////////////////////////////////////////////////////////////////
  // Controller next state.

  // Byte sequencing, pullup chaining, APB answer and status bits.
  always_comb begin
    st_nxt = st_r;
    sop_nxt = sop_r;
    mode_nxt = mode_r;
    idx_nxt = idx_r;
    data_nxt = data_r;
    rx_nxt = rx_r;
    spu_ms_nxt = spu_ms_r;
    pos_nxt = pos_r;
    owe_nxt = owe_r;
    spu_pend_nxt = spu_pend_r;
    refused_nxt = refused_r;
    pready_nxt = psel && penable && !pready_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (pready_nxt) begin
      prdata_nxt = map_ok ? rd_val : 32'h00000000;
      pslverr_nxt = !map_ok;
    end
    // Refused flag: a new refusal wins over a clear in the same cycle.
    refused_nxt = (cmd_wr && !accept) ||
                  (refused_r && !(wr_ev && paddr == `A_STATUS &&
                                  pwdata[`ST_REFUSED]));
    if (wr_ev && paddr == `A_SPU_MS) begin
      spu_ms_nxt = pwdata[15:0];
    end
    unique case (st_r)
      CTL_IDLE: begin
        if (accept) begin
          mode_nxt = opc;
          data_nxt = pwdata[15:8];
          idx_nxt = 3'h0;
          spu_pend_nxt = pwdata[`CTRL_SPU_BIT] && opc == `OPC_WRBYTE;
          st_nxt = CTL_ISSUE;
          if (opc == `OPC_RESET) begin
            sop_nxt = SLOT_RST;
            pos_nxt = 4'h0;
          end else if (opc == `OPC_WRBYTE || opc == `OPC_WRBIT) begin
            sop_nxt = SLOT_WR;
          end else begin
            sop_nxt = SLOT_RD;
          end
        end
      end
      CTL_ISSUE: begin
        st_nxt = CTL_WAIT;
      end
      CTL_WAIT: begin
        if (s.done) begin
          if (sop_r == SLOT_RD) begin
            // Received bits shift in from the top.
            rx_nxt = {s.rbit, rx_r[7:1]};
          end
          if (byte_mode && idx_r != 3'h7 && sop_r != SLOT_SPU) begin
            idx_nxt = idx_r + 3'h1;
            st_nxt = CTL_ISSUE;
          end else if (spu_pend_r && sop_r == SLOT_WR) begin
            // Pullup straight after the command byte.
            spu_pend_nxt = 1'b0;
            sop_nxt = SLOT_SPU;
            st_nxt = CTL_ISSUE;
          end else begin
            st_nxt = CTL_IDLE;
          end
        end
      end
    endcase
    // Count alarm bytes owed after a scratchpad write.
    if (wbyte_end) begin
      pos_nxt = (pos_r == 4'hF) ? pos_r : pos_r + 4'h1;
      if (owe_r != 2'h0) begin
        owe_nxt = owe_r - 2'h1;
      end else if (data_r == `CMD_WRITE_SP &&
                   (pos_r == `WSP_POS_SKIP ||
                    pos_r == `WSP_POS_MATCH)) begin
        owe_nxt = 2'h2;
      end
    end
  end

  // Controller registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= CTL_IDLE;
      sop_r <= SLOT_RST;
      mode_r <= 3'h0;
      idx_r <= 3'h0;
      data_r <= 8'h00;
      rx_r <= 8'h00;
      spu_ms_r <= `SPU_MS_RST;
      pos_r <= 4'h0;
      owe_r <= 2'h0;
      spu_pend_r <= 1'b0;
      refused_r <= 1'b0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
      dq_o_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sop_r <= sop_nxt;
      mode_r <= mode_nxt;
      idx_r <= idx_nxt;
      data_r <= data_nxt;
      rx_r <= rx_nxt;
      spu_ms_r <= spu_ms_nxt;
      pos_r <= pos_nxt;
      owe_r <= owe_nxt;
      spu_pend_r <= spu_pend_nxt;
      refused_r <= refused_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      dq_o_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slot requests and outputs.

  // Bits go out least significant first.
  assign s.start  = (st_r == CTL_ISSUE);
  assign s.op     = sop_r;
  assign s.wbit   = data_r[idx_r];
  assign s.spu_ms = spu_ms_r;

  // Every output comes from a flip-flop here or in the engine.
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign dq_o    = dq_o_r;
  assign dq_oe   = s.dq_oe;
  assign spu_oe  = s.spu_oe;

  ////////////////////////////////////////////////////////////////////////
  // Checks on byte order, pullup timing and the write guard.

  // Bits actually handed to the engine, for comparison with the byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sent_r <= 8'h00;
    end else if (s.start && sop_r == SLOT_WR) begin
      sent_r <= {s.wbit, sent_r[7:1]};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_lsb_first;
    wbyte_end |-> sent_r == data_r;
  endproperty
  a_lsb_first: assert property (p_lsb_first)
    else $error("Byte bits sent out of order.");

  property p_spu_soon;
    wbyte_end && spu_pend_r |-> ##[1:8] s.spu_oe;
  endproperty
  a_spu_soon: assert property (p_spu_soon)
    else $error("Strong pullup late after command byte.");

  property p_reset_guard;
    cmd_wr && st_r == CTL_IDLE && opc == `OPC_RESET && owe_r != 2'h0
      |=> st_r == CTL_IDLE && refused_r;
  endproperty
  a_reset_guard: assert property (p_reset_guard)
    else $error("Reset issued before both alarm bytes.");

  c_rd_byte: cover property (st_r == CTL_WAIT && s.done &&
                             mode_r == `OPC_RDBYTE && idx_r == 3'h7);
  c_spu_run: cover property ($rose(s.spu_oe));
endmodule

// *** verif/sensor_dev_model.sv ***
// Purpose: Behavioural sensor on the line, facing the bus master.
// Assumes: US is one line microsecond in ns; the line has a pull-up.
// Notes:   Serves scratchpad write, read, copy, recall and status slots.
`timescale 1ns/10ps
module sensor_dev_model #(
  parameter int US = 16
)(
  // Line.
  input  wire logic dq,
  output logic      pull
);
  logic [7:0] sp [9];
  logic [7:0] sh, rom, cmd;
  logic       rd, b, sts;
  logic [15:0] nv;
  int         nb, nbit, stat;
  realtime    t0;
  ////////////////////////////////////////////////////////////////////
  // Check over bytes 0-7.
  function automatic logic [7:0] crc8();
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 64; i++) begin
      c = (c >> 1) ^ (((c[0] ^ sp[i/8][i%8]) == 1'b1) ? 8'h8C : 8'h00);
    end
    return c;
  endfunction
  // Each fall opens a slot; a low of 480 us or more is a reset.
  initial begin
    pull = 1'b0;
    rd = 1'b0;
    sts = 1'b0;
    stat = 0;
    nv = 16'h4B46;
    nb = 0;
    nbit = 0;
    sp = '{8'h32, 8'h01, 8'h4B, 8'h46, 8'hFF, 8'hFF, 8'h0C, 8'h10, 8'h00};
    // Power-up recall loads bytes 2 and 3.
    {sp[2], sp[3]} = nv;
    forever begin
      @(negedge dq);
      t0 = $realtime;
      pull = (rd && !sp[nb][nbit]) || (sts && stat > 0);
      if (sts && stat > 0) stat--;
      #(15 * US) pull = 1'b0;
      #(15 * US) b = dq;
      if (dq !== 1'b1) @(posedge dq);
      if ($realtime - t0 >= 480 * US) begin
        rd = 1'b0;
        sts = 1'b0;
        nb = 0;
        nbit = 0;
        #(30 * US) pull = 1'b1;
        #(120 * US) pull = 1'b0;
      end else if (rd) begin
        // Bytes 0 to 8, bit 0 first.
        nbit++;
        if (nbit == 8) begin
          nbit = 0;
          nb++;
          rd = (nb < 9);
        end
      end else begin
        // Bit 0 first, after the ROM command.
        sh = {b, sh[7:1]};
        nbit++;
        if (nbit == 8) begin
          nbit = 0;
          if (nb == 0) rom = sh;
          if (nb == 1) cmd = sh;
          if (rom == 8'hCC && cmd == 8'h4E && (nb == 2 || nb == 3))
            sp[nb] = sh;
          if (rom == 8'hCC && nb == 1) begin
            // Status: one 0 slot, then 1.
            sts = (sh == 8'h44 || sh == 8'hB8 || sh == 8'hB4);
            stat = 1;
            // Copy to, recall from the stored limits.
            if (sh == 8'h48) nv = {sp[2], sp[3]};
            if (sh == 8'hB8) {sp[2], sp[3]} = nv;
          end
          if (rom == 8'hCC && nb == 1 && sh == 8'hBE) begin
            rd = 1'b1;
            nb = 0;
            sp[8] = crc8();
          end else begin
            nb++;
          end
        end
      end
    end
  end
endmodule

// *** verif/tb_sensor_bus_master.sv ***
// Purpose: Self-checking bench for the sensor bus master.
// Assumes: Counts shortened with CYC_US of 4 and MS_CYC of MSC.
// Notes:   Software sequences over APB against the sensor model.
`timescale 1ns/10ps
module tb_sensor_bus_master;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        pready, pslverr, dq_o, dq_oe, spu_oe, pull;
  wire         dq;
  int          n_fail, check_count, spu_n;
  localparam int MSC = 200;
  logic [7:0]  exp_sp [8];
  ////////////////////////////////////////////////////////////////////
  // Open-drain line with pull-up.
  assign dq = ~((dq_oe & ~dq_o) | pull);
  sensor_bus_master #(.CYC_US(4), .MS_CYC(MSC)) sensor_bus_master_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dq_i(dq), .dq_o(dq_o), .dq_oe(dq_oe),
    .spu_oe(spu_oe));
  sensor_dev_model #(.US(16)) sensor_dev_model_i (.dq(dq), .pull(pull));
  // Clock at 250 MHz.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Verdict and end of run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Compare one value.
  task automatic check(input string s, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  // One APB transfer; waits for pready under a bound.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    {rdata, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (i == 16) begin
      n_fail++;
      complete_run();
    end
  endtask
  // Issue a line operation and poll status until idle.
  task automatic op(input logic [3:0] c, input logic [7:0] d);
    int i;
    apb(1'b1, 12'h000, {16'h0000, d, 4'h0, c});
    for (i = 0; i < 9000; i++) begin
      apb(1'b0, 12'h004, 32'h0000_0000);
      if (spu_oe === 1'b1) spu_n++;
      if (rdata[0] === 1'b0) break;
    end
    if (i == 9000) begin
      n_fail++;
      complete_run();
    end
  endtask
  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    n_fail = 0;
    check_count = 0;
    spu_n = 0;
    exp_sp = '{8'h32, 8'h01, 8'hA5, 8'h3C, 8'hFF, 8'hFF, 8'h0C, 8'h10};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h008, 32'h0000_0000);
    check("spu_ms reset", 16'h02EE, rdata[15:0]);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check("unmapped error", 16'h0001, 16'(err));
    op(3'h1, 8'h00);
    op(3'h2, 8'hCC);
    op(3'h2, 8'h4E);
    op(3'h1, 8'h00);
    check("reset refused", 16'h0001, 16'(rdata[5]));
    apb(1'b1, 12'h004, 32'h0000_0020);
    op(3'h2, 8'hA5);
    op(3'h2, 8'h3C);
    // Full read, read cut short by reset, command with no ROM command.
    for (int k = 0; k < 3; k++) begin
      op(3'h1, 8'h00);
      check("presence", 16'h0001, 16'({rdata[5], rdata[1]}));
      if (k < 2) op(3'h2, 8'hCC);
      op(3'h2, 8'hBE);
      for (int j = 0; j < ((k == 0) ? 9 : 1); j++) begin
        op(3'h3, 8'h00);
        if (j < 8) check("rx byte", 16'((k == 2) ? 8'hFF : exp_sp[j]),
                         16'(rdata[15:8]));
      end
      if (k == 0) check("crc good", 16'h0001, 16'(rdata[2]));
    end
    // Conversion with the strong pullup, then two status read slots.
    apb(1'b1, 12'h008, 32'h0000_0005);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check("spu_ms", 16'h0005, rdata[15:0]);
    op(4'h1, 8'h00);
    op(4'h2, 8'hCC);
    spu_n = 0;
    op(4'hA, 8'h44);
    check("spu", 16'h0001, 16'(spu_n >= 10 * MSC / 4 - 1));
    check("spu off", 16'h0000, 16'(spu_oe));
    op(4'h4, 8'h00);
    check("status busy", 16'h0000, 16'(rdata[4]));
    op(4'h4, 8'h00);
    check("status done", 16'h0001, 16'(rdata[4]));
    complete_run();
  end
endmodule
